// file: hw/ipm_irq_detect.sv
`timescale 1ns/1ps
module ipm_irq_detect
   import ipm_pkg::*;
(
   input  wire logic      aclk,
   input  wire logic      aresetn,
   input  wire logic      pin_in,
   input  wire logic      enable,
   input  wire ipm_trig_t trig,
   output logic           pin_sync,
   output logic           event_p
);

   logic      meta_q;
   logic      sync_q;
   logic      prev_q;
   logic      rise;
   logic      fall;
   logic      hit;

   // Two flops before any edge logic looks at the pin.
   // Reset to the pulled-up idle level so that no false rising edge follows reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         meta_q <= pin_in;   // [RULE_13]
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
   // Level mode asserts while the pin is low, the usual sense of a pulled-up line.
   assign hit  = (trig == IPM_TRIG_RISE) ? rise :
                 (trig == IPM_TRIG_FALL) ? fall : ~sync_q;   // [RULE_03]

   assign pin_sync = sync_q;
   assign event_p  = enable & hit;   // [RULE_13]

endmodule

// file: hw/ipm_pin_mux.sv
// Functional notes
// RULE_01: Select input low routes normal functions; high routes alternate functions.
// RULE_02: In normal selection each pin is software-set as interrupt or GPIO.
// RULE_03: Interrupt detection is level, rising edge or falling edge per pin.
// RULE_04: Pins not set as interrupts are GPIO; reset leaves them GPIO inputs.
// RULE_05: Codec transmit role drives the first pin from the transmit shift data.
// RULE_06: Using the alternate transmit pin disables the primary transmit data pin.
// RULE_07: First pin as GPIO output can serve as port A set-ready output.
// RULE_08: First pin is GPIO without special function and resets as GPIO input; in alternate selection the code never drives it, so it is an input only.
// RULE_09: Alternate selection makes second pin the test reset, asynchronously resetting TAP.
// RULE_10: Enabled alternate test reset disconnects the primary test reset pin.
// RULE_11: Codec receive role feeds the second pin into the receive shift register.
// RULE_12: Using the alternate receive pin disables the primary receive data pin.
// RULE_13: Pins are synchronised before edge detection; one request per qualifying edge.
`timescale 1ns/1ps
module ipm_pin_mux
   import ipm_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [IPM_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [IPM_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  pin_function_select,
   input  wire logic                  ext_irq_line_six_i,
   output logic                       ext_irq_line_six_o,
   output logic                       ext_irq_line_six_oe,
   input  wire logic                  ext_irq_line_seven_i,
   output logic                       ext_irq_line_seven_o,
   output logic                       ext_irq_line_seven_oe,
   input  wire logic                  codec_tx_shift_data,
   output logic                       codec_tx_primary_en,
   output logic                       codec_rx_shift_data,
   input  wire logic                  codec_rx_primary_data,
   output logic                       codec_rx_primary_en,
   input  wire logic                  port_a_set_ready,
   output logic                       port_a_set_ready_en,
   input  wire logic                  test_reset_primary_n,
   output logic                       tap_reset_n,
   output logic                       ext_irq_six_req,
   output logic                       ext_irq_seven_req,
   output logic                       irq
);

   ipm_pin_cfg_t cfg0_q;
   ipm_pin_cfg_t cfg1_q;
   logic [1:0]   stat_q;
   logic [1:0]   stat_d;
   logic [1:0]   mask_q;
   logic         aw_have_q;
   logic         w_have_q;
   logic [IPM_ADDR_W-1:0] awaddr_q;
   logic [31:0]  wdata_q;
   logic [3:0]   wstrb_q;
   logic         bvalid_q;
   logic [1:0]   bresp_q;
   logic         rvalid_q;
   logic [31:0]  rdata_q;
   logic [1:0]   rresp_q;
   logic         six_req_q;
   logic         seven_req_q;

   logic         alt_sel;
   logic         six_is_irq;
   logic         seven_is_irq;
   logic         six_is_alt;
   logic         six_sync;
   logic         seven_sync;
   logic         six_ev;
   logic         seven_ev;
   logic         do_write;
   logic         do_read;
   logic         wr_ok;
   logic         rd_ok;
   logic         stat_read;
   logic [31:0]  rd_word;
   logic [1:0]   ev_vec;

   function automatic logic addr_hit(input logic [IPM_ADDR_W-1:0] a);
      addr_hit = (a == IPM_OFF_CFG0) || (a == IPM_OFF_CFG1) || (a == IPM_OFF_GPIO) ||
                 (a == IPM_OFF_STAT) || (a == IPM_OFF_MASK) || (a == IPM_OFF_PINS);
   endfunction

   // Pin function decode.
   assign alt_sel      = pin_function_select;   // [RULE_01]
   assign six_is_irq   = !alt_sel && (cfg0_q.func == IPM_FN_IRQ);   // [RULE_02]
   assign seven_is_irq = !alt_sel && (cfg1_q.func == IPM_FN_IRQ);   // [RULE_02]
   assign six_is_alt   = !alt_sel && (cfg0_q.func == IPM_FN_ALT);

   ipm_irq_detect u_det_six (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin_in   (ext_irq_line_six_i),
      .enable   (six_is_irq),
      .trig     (cfg0_q.trig),
      .pin_sync (six_sync),
      .event_p  (six_ev)
   );

   ipm_irq_detect u_det_seven (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin_in   (ext_irq_line_seven_i),
      .enable   (seven_is_irq),
      .trig     (cfg1_q.trig),
      .pin_sync (seven_sync),
      .event_p  (seven_ev)
   );

   // First pin: alternate codec transmit takes priority over GPIO output.
   // Only the first pin's normal roles exist, so alternate selection leaves it an input.
   assign codec_tx_primary_en  = ~six_is_alt;   // [RULE_06]
   assign port_a_set_ready_en  = !alt_sel && (cfg0_q.func == IPM_FN_GPIO) && cfg0_q.out_en;   // [RULE_07]

   // Second pin: test reset in alternate selection, codec receive or GPIO otherwise.
   // Test reset is combinational so the TAP sees it without a clock.
   assign tap_reset_n           = alt_sel ? ext_irq_line_seven_i : test_reset_primary_n;   // [RULE_09] [RULE_10]
   assign codec_rx_shift_data   = (!alt_sel && cfg1_q.func == IPM_FN_ALT) ?
                                  ext_irq_line_seven_i : codec_rx_primary_data;   // [RULE_11]
   assign codec_rx_primary_en   = !(!alt_sel && cfg1_q.func == IPM_FN_ALT);   // [RULE_12]

   // Pin drivers registered; reset leaves both pins as inputs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_irq_line_six_o    <= 1'b0;
         ext_irq_line_six_oe   <= 1'b0;   // [RULE_04] [RULE_08]
         ext_irq_line_seven_o  <= 1'b0;
         ext_irq_line_seven_oe <= 1'b0;   // [RULE_04]
      end else begin
         ext_irq_line_six_oe   <= six_is_alt | port_a_set_ready_en;   // [RULE_05] [RULE_08]
         ext_irq_line_six_o    <= six_is_alt ? codec_tx_shift_data :
                                  (cfg0_q.out_val | port_a_set_ready);   // [RULE_05] [RULE_07]
         ext_irq_line_seven_oe <= !alt_sel && (cfg1_q.func == IPM_FN_GPIO) && cfg1_q.out_en;   // [RULE_04]
         ext_irq_line_seven_o  <= cfg1_q.out_val;
      end
   end

   // Pending requests: one per qualifying event, held until read.
   assign ev_vec    = {seven_ev, six_ev};
   assign stat_read = do_read && (s_axi_araddr == IPM_OFF_STAT);
   // A new event in the clearing cycle stays set.
   assign stat_d    = (stat_read ? 2'b00 : stat_q) | ev_vec;   // [RULE_13]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q      <= 2'b00;
         six_req_q   <= 1'b0;
         seven_req_q <= 1'b0;
      end else begin
         stat_q      <= stat_d;
         six_req_q   <= six_ev;   // [RULE_13]
         seven_req_q <= seven_ev;
      end
   end

   assign ext_irq_six_req   = six_req_q;
   assign ext_irq_seven_req = seven_req_q;
   assign irq               = |(stat_q & mask_q);

   // AXI4-Lite write path: address and data latched independently.
   assign s_axi_awready = ~aw_have_q & ~bvalid_q;
   assign s_axi_wready  = ~w_have_q & ~bvalid_q;
   assign do_write      = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_ok         = addr_hit(awaddr_q) && (awaddr_q != IPM_OFF_STAT) && (awaddr_q != IPM_OFF_PINS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= IPM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? IPM_RESP_OKAY : IPM_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // Configuration registers; only byte lane 0 carries fields.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg0_q <= IPM_CFG_RST;   // [RULE_04] [RULE_08]
         cfg1_q <= IPM_CFG_RST;
         mask_q <= 2'b00;
      end else if (do_write && wstrb_q[0]) begin
         if (awaddr_q == IPM_OFF_CFG0) begin
            cfg0_q <= wdata_q[5:0];
         end
         if (awaddr_q == IPM_OFF_CFG1) begin
            cfg1_q <= wdata_q[5:0];
         end
         if (awaddr_q == IPM_OFF_GPIO) begin
            cfg0_q.out_val <= wdata_q[0];
            cfg1_q.out_val <= wdata_q[1];
         end
         if (awaddr_q == IPM_OFF_MASK) begin
            mask_q <= wdata_q[1:0];
         end
      end
   end

   // AXI4-Lite read path.
   assign s_axi_arready = ~rvalid_q;
   assign do_read       = s_axi_arvalid & s_axi_arready;
   assign rd_ok         = addr_hit(s_axi_araddr);
   assign rd_word       = (s_axi_araddr == IPM_OFF_CFG0) ? {26'h000_0000, cfg0_q} :
                          (s_axi_araddr == IPM_OFF_CFG1) ? {26'h000_0000, cfg1_q} :
                          (s_axi_araddr == IPM_OFF_GPIO) ? {30'h0000_0000, cfg1_q.out_val, cfg0_q.out_val} :
                          (s_axi_araddr == IPM_OFF_STAT) ? {30'h0000_0000, stat_q} :
                          (s_axi_araddr == IPM_OFF_MASK) ? {30'h0000_0000, mask_q} :
                          (s_axi_araddr == IPM_OFF_PINS) ? {29'h0000_0000, alt_sel, seven_sync, six_sync} :
                          32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= IPM_RESP_OKAY;
      end else if (do_read) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_ok ? IPM_RESP_OKAY : IPM_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

endmodule

// file: hw/ipm_pkg.sv
package ipm_pkg;

   // Register byte offsets.
   localparam logic [7:0] IPM_OFF_CFG0   = 8'h00;
   localparam logic [7:0] IPM_OFF_CFG1   = 8'h04;
   localparam logic [7:0] IPM_OFF_GPIO   = 8'h08;
   localparam logic [7:0] IPM_OFF_STAT   = 8'h0C;
   localparam logic [7:0] IPM_OFF_MASK   = 8'h10;
   localparam logic [7:0] IPM_OFF_PINS   = 8'h14;

   localparam int IPM_ADDR_W = 8;

   // Pin configuration register fields.
   localparam int IPM_CFG_FUNC_LSB = 0;
   localparam int IPM_CFG_TRIG_LSB = 2;
   localparam int IPM_CFG_OE_BIT   = 4;
   localparam int IPM_CFG_OUT_BIT  = 5;

   // Normal-mode pin function.
   typedef enum logic [1:0] {
      IPM_FN_GPIO = 2'h0,
      IPM_FN_IRQ  = 2'h1,
      IPM_FN_ALT  = 2'h2
   } ipm_func_t;

   typedef enum logic [1:0] {
      IPM_TRIG_LEVEL = 2'h0,
      IPM_TRIG_RISE  = 2'h1,
      IPM_TRIG_FALL  = 2'h2
   } ipm_trig_t;

   typedef struct packed {
      logic      out_val;
      logic      out_en;
      ipm_trig_t trig;
      ipm_func_t func;
   } ipm_pin_cfg_t;

   localparam logic [5:0] IPM_CFG_RST = 6'h00;

   typedef enum logic [2:0] {
      IPM_ST_IDLE = 3'b001,
      IPM_ST_SYNC = 3'b010,
      IPM_ST_RUN  = 3'b100
   } ipm_det_state_t;

   localparam logic [1:0] IPM_RESP_OKAY   = 2'h0;
   localparam logic [1:0] IPM_RESP_SLVERR = 2'h2;

endpackage

// file: testbench/ipm_checker.sv
`timescale 1ns/1ps
module ipm_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_function_select,
   input wire logic ext_irq_line_six_o,
   input wire logic ext_irq_line_six_oe,
   input wire logic ext_irq_line_seven_i,
   input wire logic ext_irq_line_seven_oe,
   input wire logic codec_tx_shift_data,
   input wire logic codec_tx_primary_en,
   input wire logic codec_rx_shift_data,
   input wire logic codec_rx_primary_data,
   input wire logic codec_rx_primary_en,
   input wire logic port_a_set_ready_en,
   input wire logic test_reset_primary_n,
   input wire logic tap_reset_n,
   input wire logic ext_irq_seven_req
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Five cycles cover the synchroniser and edge stages of the detector.
   sequence alt_held;
      pin_function_select [*5];
   endsequence
   tap_alt_a: assert property (pin_function_select |-> tap_reset_n == ext_irq_line_seven_i)
      else $error("tap reset not from second pin");
   tap_primary_a: assert property (!pin_function_select |-> tap_reset_n == test_reset_primary_n)
      else $error("tap reset not from primary pin");
   rx_alt_a: assert property (!codec_rx_primary_en |-> codec_rx_shift_data == ext_irq_line_seven_i)
      else $error("receive data not from second pin");
   rx_primary_a: assert property (codec_rx_primary_en |-> codec_rx_shift_data == codec_rx_primary_data)
      else $error("receive data not from primary pin");
   tx_alt_a: assert property (!codec_tx_primary_en [*2] |->
      ext_irq_line_six_oe && ext_irq_line_six_o == $past(codec_tx_shift_data))
      else $error("first pin not carrying transmit data");
   set_ready_a: assert property (port_a_set_ready_en [*2] |-> ext_irq_line_six_oe)
      else $error("set-ready output not driven");
   seven_input_a: assert property (alt_held |-> !ext_irq_line_seven_oe)
      else $error("second pin driven in alternate selection");
   seven_quiet_a: assert property (alt_held |-> !ext_irq_seven_req)
      else $error("interrupt from second pin in alternate selection");
endmodule
bind ipm_pin_mux ipm_checker u_chk (.*);

// file: testbench/ipm_pins_model.sv
`timescale 1ns/1ps
module ipm_pins_model (
   input  wire logic oe,
   input  wire logic o,
   input  wire logic drv_en,
   input  wire logic drv_val,
   output logic      line
);
   // A released pin reads high through its pull-up; the block wins when both drive.
   assign line = oe ? o : (drv_en ? drv_val : 1'h1);
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb
   import ipm_pkg::*;
;
   logic aclk = 1'h0, aresetn = 1'h0, pin_function_select = 1'h0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic codec_tx_shift_data = 0, codec_rx_primary_data = 0, port_a_set_ready = 0, test_reset_primary_n = 1;
   logic d6 = 0, v6 = 0, d7 = 0, v7 = 0;
   logic ext_irq_line_six_i, ext_irq_line_six_o, ext_irq_line_six_oe, ext_irq_line_seven_i;
   logic ext_irq_line_seven_o, ext_irq_line_seven_oe, codec_tx_primary_en, codec_rx_shift_data;
   logic codec_rx_primary_en, port_a_set_ready_en, tap_reset_n, ext_irq_six_req, ext_irq_seven_req, irq;
   int err_count = 0, n_checks = 0, cyc = 0, n7 = 0, n6 = 0;
   ipm_pin_mux DUT (.*);
   ipm_pins_model u_p6 (.oe(ext_irq_line_six_oe), .o(ext_irq_line_six_o), .drv_en(v6), .drv_val(d6),
                        .line(ext_irq_line_six_i));
   ipm_pins_model u_p7 (.oe(ext_irq_line_seven_oe), .o(ext_irq_line_seven_o), .drv_en(v7), .drv_val(d7),
                        .line(ext_irq_line_seven_i));
   always #20 aclk = ~aclk;
   always @(negedge aclk) if (ext_irq_seven_req) n7++;
   always @(negedge aclk) if (ext_irq_six_req) n6++;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'h1) begin
         err_count++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic aw, w, b;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 0;
         if (w) s_axi_wvalid <= 0;
      end while (b !== 1'h1);
      s_axi_bready <= 0;
      chk(r === e, "write response");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ar, g;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         g = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 0;
      end while (g !== 1'h1);
      s_axi_rready <= 0;
      chk(r === er && (er !== IPM_RESP_OKAY || d === e), "read value");
   endtask
   task automatic t_reset();
      chk(!ext_irq_line_six_oe && !ext_irq_line_seven_oe && !irq, "pins after reset");
      rd(IPM_OFF_CFG0, 32'h0, IPM_RESP_OKAY);
      rd(IPM_OFF_CFG1, 32'h0, IPM_RESP_OKAY);
      rd(IPM_OFF_PINS, 32'h3, IPM_RESP_OKAY);
      rd(8'h18, 32'h0, IPM_RESP_SLVERR);
      wr(8'h18, 32'h0, IPM_RESP_SLVERR);
      wr(IPM_OFF_STAT, 32'h3, IPM_RESP_SLVERR);
   endtask
   task automatic t_dsr();
      wr(IPM_OFF_CFG0, 32'h10, IPM_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(port_a_set_ready_en && ext_irq_line_six_oe && ext_irq_line_six_o === 1'h0, "gpio out");
      port_a_set_ready <= 1;
      repeat (3) @(posedge aclk);
      chk(ext_irq_line_six_o === 1'h1, "set-ready level");
      port_a_set_ready <= 0;
   endtask
   task automatic t_codec();
      wr(IPM_OFF_CFG0, 32'h2, IPM_RESP_OKAY);
      wr(IPM_OFF_CFG1, 32'h2, IPM_RESP_OKAY);
      v7 <= 1;
      for (int i = 0; i < 2; i++) begin
         codec_tx_shift_data <= i[0];
         d7 <= ~i[0];
         repeat (3) @(posedge aclk);
         chk(!codec_tx_primary_en && ext_irq_line_six_o === i[0], "alt transmit");
         chk(!codec_rx_primary_en && codec_rx_shift_data === ~i[0], "alt receive");
      end
      wr(IPM_OFF_CFG1, 32'h0, IPM_RESP_OKAY);
      codec_rx_primary_data <= 1;
      @(posedge aclk);
      chk(codec_rx_primary_en && codec_rx_shift_data === 1'h1, "primary receive");
      wr(IPM_OFF_CFG0, 32'h0, IPM_RESP_OKAY);
   endtask
   // The first pin idles high through its pull-up; pulling it low gives one falling edge.
   task automatic t_six();
      wr(IPM_OFF_CFG0, 32'h9, IPM_RESP_OKAY);
      wr(IPM_OFF_MASK, 32'h1, IPM_RESP_OKAY);
      n6 = 0;
      v6 <= 1;
      repeat (8) @(posedge aclk);
      chk(n6 == 1 && irq === 1'h1, "first pin falling edge");
      v6 <= 0;
      rd(IPM_OFF_STAT, 32'h1, IPM_RESP_OKAY);
      wr(IPM_OFF_CFG0, 32'h0, IPM_RESP_OKAY);
   endtask
   // Level mode reacts to a low pin every cycle, so it must see more than one request.
   task automatic t_irq(input ipm_trig_t tr, input logic s, input logic [31:0] m);
      d7 <= s;
      v7 <= 1;
      wr(IPM_OFF_CFG1, 32'({tr, IPM_FN_IRQ}), IPM_RESP_OKAY);
      wr(IPM_OFF_MASK, m, IPM_RESP_OKAY);
      repeat (8) @(posedge aclk);
      rd(IPM_OFF_STAT, 32'h0, IPM_RESP_OKAY);
      n7 = 0;
      d7 <= ~s;
      repeat (8) @(posedge aclk);
      chk(tr == IPM_TRIG_LEVEL ? n7 > 1 : n7 == 1, "request count");
      chk(irq === m[1], "irq level");
      d7 <= s;
      repeat (8) @(posedge aclk);
      rd(IPM_OFF_STAT, 32'h2, IPM_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(irq === 1'h0, "irq after clear");
      // Back to GPIO so that the next scenario's pin setup raises no request.
      wr(IPM_OFF_CFG1, 32'h0, IPM_RESP_OKAY);
   endtask
   task automatic t_alt();
      wr(IPM_OFF_CFG1, 32'h10, IPM_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(ext_irq_line_seven_oe === 1'h1, "gpio drive");
      wr(IPM_OFF_GPIO, 32'h2, IPM_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(ext_irq_line_seven_o === 1'h1, "gpio value");
      rd(IPM_OFF_PINS, 32'h3, IPM_RESP_OKAY);
      pin_function_select <= 1;
      repeat (3) @(posedge aclk);
      chk(ext_irq_line_seven_oe === 1'h0, "alt pin is input");
      for (int i = 0; i < 2; i++) begin
         @(posedge aclk);
         d7 <= i[0];
         test_reset_primary_n <= ~i[0];
         #1 chk(tap_reset_n === i[0], "alt test reset");
      end
      repeat (6) @(posedge aclk);
      pin_function_select <= 0;
      @(posedge aclk);
      #1 chk(tap_reset_n === test_reset_primary_n, "primary test reset");
      wr(IPM_OFF_CFG1, 32'h0, IPM_RESP_OKAY);
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_dsr();
      t_codec();
      t_six();
      t_irq(IPM_TRIG_RISE, 1'h0, 32'h2);
      t_irq(IPM_TRIG_FALL, 1'h1, 32'h2);
      t_irq(IPM_TRIG_LEVEL, 1'h1, 32'h2);
      t_irq(IPM_TRIG_RISE, 1'h0, 32'h0);
      t_alt();
      end_sim();
   end
endmodule
